// [logic/mps_low_filter.sv]
// Qualifies low pulses on an active-low control line.
// Assumes the line level is synchronous to sys_clk and high when idle.
`timescale 1ns/100ps
`include "mps_params.svh"

module mps_low_filter #(
   parameter int unsigned MIN_CYC = 16
) (
   input wire logic sys_clk, // System clock
   input wire logic srst, // Synchronous reset, high
   input wire logic lineIn, // Line level, low means asserted
   output logic lowValid, // Held low at least MIN_CYC cycles
   output logic validRelease // Pulse: release after a valid low
);
   localparam logic [`MPS_LOW_CNT_W-1:0] MinM1 = `MPS_LOW_CNT_W'(MIN_CYC - 1);

   mps_pkg::mps_filt_s filtReg;
   mps_pkg::mps_filt_s filtNext;

   // Count low time; saturating so a long hold never wraps
   always_comb begin
      filtNext = filtReg;
      filtNext.validRelease = 1'b0;
      if (!lineIn) begin
         if (filtReg.lowCnt != '1) begin
            filtNext.lowCnt = filtReg.lowCnt + `MPS_LOW_CNT_W'(1);
         end
         filtNext.heldValid = (filtReg.lowCnt >= MinM1);
      end else begin
         filtNext.lowCnt = '0;
         filtNext.heldValid = 1'b0;
         // Short pulses end here with no effect
         filtNext.validRelease = filtReg.wasLow && filtReg.heldValid;
      end
      filtNext.wasLow = !lineIn;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         filtReg <= '0;
      end else begin
         filtReg <= filtNext;
      end
   end

   assign lowValid = filtReg.heldValid;
   assign validRelease = filtReg.validRelease;
endmodule

// [logic/mps_sequencer.sv]
// Module power state sequencer: switch-on, graceful and abrupt off, resets.
// Assumes supply, line and temperature inputs are synchronous to sys_clk;
// firmware answers save and detach requests; the alarm comes from the
// always-on clock block, which this logic never resets.
`timescale 1ns/100ps
`include "mps_params.svh"

module mps_sequencer #(
   parameter int unsigned KEY_MIN_CYC = `MPS_KEY_MIN_LOW_CYC, // Power key low
   parameter int unsigned RST_MIN_CYC = `MPS_RST_MIN_LOW_CYC // Reset line low
) (
   input wire logic sys_clk, // 125 MHz clock
   input wire logic srst, // Synchronous reset, high
   input wire logic supplyGood, // Main supply within range
   input wire logic powerKeyIn, // Power key line level
   input wire logic resetLineIn, // Reset line level
   input wire logic rtcAlarm, // Alarm time reached
   input wire logic powerOffCmd, // Pulse: power off command
   input wire logic funcResetCmd, // Pulse: function level reset
   input wire logic tempSupEnable, // Temperature supervisor on
   input wire logic tempSupConfigured, // Its limits are set
   input wire logic tempOverLimit, // Board above limit
   input wire logic tempUnderLimit, // Board below limit
   input wire logic saveDone, // Settings stored
   input wire logic detachDone, // Network detach finished
   output logic saveReq, // Store settings request
   output logic detachReq, // Network detach request
   output logic intSupplyEn, // 1.8 V interface supply enable
   output logic pinsHiZ, // Digital pins released
   output logic coreRun, // Baseband out of reset
   output logic rtcFromMain, // Clock block fed from main supply
   output logic keyPullUpEn, // Power key pull-up enable
   output logic resetPullUpEn, // Reset line pull-up enable
   output logic [`MPS_STATE_W-1:0] powerState // One-hot power state
);
   mps_pkg::mps_seq_s seqReg;
   mps_pkg::mps_seq_s seqNext;

   logic keyLowValid;
   logic keyRelease;
   logic rstLowValid;
   logic rstRelease;
   logic saveFin;
   logic detachFin;
   logic stepAbort;
   logic tempTrip;
   logic alarmRise;
   logic linesHigh;
   logic switchedOn;

   // Qualified power key pulses
   mps_low_filter #(
      .MIN_CYC(KEY_MIN_CYC)
   ) keyFilter (
      .sys_clk(sys_clk),
      .srst(srst),
      .lineIn(powerKeyIn),
      .lowValid(keyLowValid),
      .validRelease(keyRelease)
   );

   // Qualified reset line pulses
   mps_low_filter #(
      .MIN_CYC(RST_MIN_CYC)
   ) rstFilter (
      .sys_clk(sys_clk),
      .srst(srst),
      .lineIn(resetLineIn),
      .lowValid(rstLowValid),
      .validRelease(rstRelease)
   );

   // Settings save step
   mps_step saveStep (
      .sys_clk(sys_clk),
      .srst(srst),
      .start(seqReg.startSave),
      .abort(stepAbort),
      .doneIn(saveDone),
      .req(saveReq),
      .donePulse(saveFin)
   );

   // Network detach step
   mps_step detachStep (
      .sys_clk(sys_clk),
      .srst(srst),
      .start(seqReg.startDetach),
      .abort(stepAbort),
      .doneIn(detachDone),
      .req(detachReq),
      .donePulse(detachFin)
   );

   // Abrupt events cut any pending step, no save and no detach
   assign stepAbort = !supplyGood || rstLowValid;
   // Trip only when the supervisor is both enabled and configured
   assign tempTrip = tempSupEnable && tempSupConfigured
                     && (tempOverLimit || tempUnderLimit);
   assign alarmRise = rtcAlarm && !seqReg.alarmWas;
   // Host may only pull low; high means nobody is pulling
   assign linesHigh = powerKeyIn && resetLineIn;

   // State transitions; supply loss outranks everything
   always_comb begin
      seqNext = seqReg;
      seqNext.startSave = 1'b0;
      seqNext.startDetach = 1'b0;
      seqNext.alarmWas = rtcAlarm;
      if (!supplyGood) begin
         seqNext.state = mps_pkg::MPS_NOSUP;
         seqNext.rebootPend = 1'b0;
      end else begin
         unique case (seqReg.state)
            mps_pkg::MPS_NOSUP: begin
               // Supply has just come up
               if (linesHigh) begin
                  seqNext.state = mps_pkg::MPS_ON;
               end else begin
                  seqNext.state = mps_pkg::MPS_HOLDOFF;
               end
            end
            mps_pkg::MPS_HOLDOFF: begin
               // Switch on only once the host lets go
               if (linesHigh) begin
                  seqNext.state = mps_pkg::MPS_ON;
               end
            end
            mps_pkg::MPS_OFF: begin
               if (keyRelease) begin
                  seqNext.state = mps_pkg::MPS_ON;
               end else if (rstRelease) begin
                  seqNext.state = mps_pkg::MPS_ON;
               end else if (alarmRise) begin
                  seqNext.state = mps_pkg::MPS_ON;
               end
            end
            mps_pkg::MPS_ON: begin
               if (rstLowValid) begin
                  seqNext.state = mps_pkg::MPS_HWRST;
               end else if (tempTrip) begin
                  seqNext.state = mps_pkg::MPS_OFF;
               end else if (powerOffCmd || keyRelease) begin
                  seqNext.state = mps_pkg::MPS_SAVE;
                  seqNext.rebootPend = 1'b0;
                  seqNext.startSave = 1'b1;
               end else if (funcResetCmd) begin
                  seqNext.state = mps_pkg::MPS_SAVE;
                  seqNext.rebootPend = 1'b1;
                  seqNext.startSave = 1'b1;
               end
            end
            mps_pkg::MPS_SAVE: begin
               if (rstLowValid) begin
                  seqNext.state = mps_pkg::MPS_HWRST;
               end else if (saveFin) begin
                  seqNext.state = mps_pkg::MPS_DETACH;
                  seqNext.startDetach = 1'b1;
               end
            end
            mps_pkg::MPS_DETACH: begin
               if (rstLowValid) begin
                  seqNext.state = mps_pkg::MPS_HWRST;
               end else if (detachFin) begin
                  if (seqReg.rebootPend) begin
                     seqNext.state = mps_pkg::MPS_REBOOT;
                  end else begin
                     seqNext.state = mps_pkg::MPS_OFF;
                  end
               end
            end
            mps_pkg::MPS_HWRST: begin
               // Held in reset until the line is released
               seqNext.rebootPend = 1'b0;
               if (rstRelease) begin
                  seqNext.state = mps_pkg::MPS_ON;
               end
            end
            mps_pkg::MPS_REBOOT: begin
               // One cycle with the core held, then run again
               seqNext.rebootPend = 1'b0;
               seqNext.state = mps_pkg::MPS_ON;
            end
            default: begin
               seqNext.state = mps_pkg::MPS_NOSUP;
            end
         endcase
      end

      // Outputs follow the next state so they change with it
      switchedOn = (seqNext.state == mps_pkg::MPS_ON)
                   || (seqNext.state == mps_pkg::MPS_SAVE)
                   || (seqNext.state == mps_pkg::MPS_DETACH);
      seqNext.intSupplyEn = switchedOn;
      seqNext.pinsHiZ = !switchedOn;
      seqNext.coreRun = switchedOn;
      // Clock block stays alive either way; only its feed changes
      seqNext.rtcFromMain = supplyGood;
      seqNext.pullUpEn = 1'b1;
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         seqReg.state <= mps_pkg::MPS_NOSUP;
         seqReg.rebootPend <= 1'b0;
         seqReg.intSupplyEn <= 1'b0;
         seqReg.pinsHiZ <= 1'b1;
         seqReg.coreRun <= 1'b0;
         seqReg.rtcFromMain <= 1'b0;
         seqReg.pullUpEn <= 1'b1;
         seqReg.startSave <= 1'b0;
         seqReg.startDetach <= 1'b0;
         seqReg.alarmWas <= 1'b0;
      end else begin
         seqReg <= seqNext;
      end
   end

   // Registered outputs
   assign intSupplyEn = seqReg.intSupplyEn;
   assign pinsHiZ = seqReg.pinsHiZ;
   assign coreRun = seqReg.coreRun;
   assign rtcFromMain = seqReg.rtcFromMain;
   assign keyPullUpEn = seqReg.pullUpEn;
   assign resetPullUpEn = seqReg.pullUpEn;
   assign powerState = seqReg.state;
endmodule

// [logic/mps_step.sv]
// One request/done handshake step towards the firmware side.
// Assumes done is a level or pulse raised only while req is high.
`timescale 1ns/100ps

module mps_step (
   input wire logic sys_clk, // System clock
   input wire logic srst, // Synchronous reset, high
   input wire logic start, // Pulse: begin the step
   input wire logic abort, // Drop the request at once
   input wire logic doneIn, // Firmware reports completion
   output logic req, // Request level, registered
   output logic donePulse // Pulse: step finished
);
   mps_pkg::mps_step_s stepReg;
   mps_pkg::mps_step_s stepNext;

   // Abort beats completion: an abrupt off must not look finished
   always_comb begin
      stepNext = stepReg;
      stepNext.done = 1'b0;
      if (abort) begin
         stepNext.req = 1'b0;
      end else if (stepReg.req) begin
         if (doneIn) begin
            stepNext.req = 1'b0;
            stepNext.done = 1'b1;
         end
      end else if (start) begin
         stepNext.req = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stepReg <= '0;
      end else begin
         stepReg <= stepNext;
      end
   end

   assign req = stepReg.req;
   assign donePulse = stepReg.done;
endmodule

// [shared/mps_params.svh]
// Constants for the module power state sequencer: timing and widths.
// Assumes one 125 MHz clock and pin levels already synchronous to it.
`ifndef MPS_PARAMS_SVH
`define MPS_PARAMS_SVH

`define MPS_CLK_PERIOD_NS 8
`define MPS_KEY_MIN_LOW_NS 50000
`define MPS_RST_MIN_LOW_NS 10000
`define MPS_KEY_MIN_LOW_CYC \
   ((`MPS_KEY_MIN_LOW_NS + `MPS_CLK_PERIOD_NS - 1) / `MPS_CLK_PERIOD_NS)
`define MPS_RST_MIN_LOW_CYC \
   ((`MPS_RST_MIN_LOW_NS + `MPS_CLK_PERIOD_NS - 1) / `MPS_CLK_PERIOD_NS)
`define MPS_LOW_CNT_W 20
`define MPS_STATE_W 8

`endif

// [shared/mps_pkg.sv]
// Types shared by the power state sequencer and its helpers.
// Assumes mps_params.svh is on the include path.
`include "mps_params.svh"

package mps_pkg;

   // Power states, one-hot
   typedef enum logic [`MPS_STATE_W-1:0] {
      MPS_NOSUP   = 8'h01, // No main supply
      MPS_HOLDOFF = 8'h02, // Supply up, a line still held low
      MPS_OFF     = 8'h04, // Power-off with supply present
      MPS_ON      = 8'h08,
      MPS_SAVE    = 8'h10, // Storing settings
      MPS_DETACH  = 8'h20, // Leaving the network
      MPS_HWRST   = 8'h40, // Reset line held low
      MPS_REBOOT  = 8'h80
   } mps_state_e;

   // Low pulse qualifier state
   typedef struct packed {
      logic [`MPS_LOW_CNT_W-1:0] lowCnt;
      logic wasLow;
      logic heldValid;
      logic validRelease;
   } mps_filt_s;

   // Request and done handshake state
   typedef struct packed {
      logic req;
      logic done;
   } mps_step_s;

   // Sequencer state
   typedef struct packed {
      mps_state_e state;
      logic rebootPend;
      logic intSupplyEn;
      logic pinsHiZ;
      logic coreRun;
      logic rtcFromMain;
      logic pullUpEn;
      logic startSave;
      logic startDetach;
      logic alarmWas;
   } mps_seq_s;

endpackage

// [sim/mps_host_model.sv]
// Host side of the power sequencer: open-drain key and reset lines, firmware answers.
// Assumes the bench sets keyDrvLow, rstDrvLow and slow at the falling edge.
`timescale 1ns/100ps

module mps_host_model (
   input wire logic sys_clk, // System clock
   input wire logic srst, // Synchronous reset, high
   input wire logic keyDrvLow, // Host pulls the power key low
   input wire logic rstDrvLow, // Host pulls the reset line low
   input wire logic slow, // Answer requests late
   input wire logic keyPullUpEn, // Device pull-up on the key line
   input wire logic resetPullUpEn, // Device pull-up on the reset line
   input wire logic saveReq, // Store settings request
   input wire logic detachReq, // Network detach request
   output logic powerKeyIn, // Resolved key line
   output logic resetLineIn, // Resolved reset line
   output logic saveDone, // Settings stored
   output logic detachDone // Detach finished
);
   logic flip;
   logic [3:0] saveDly;
   logic [3:0] detDly;

   // Floating line toggles, so a stale level is never mistaken for idle
   always_ff @(posedge sys_clk) begin
      flip <= srst ? 1'b0 : ~flip;
      saveDly <= {saveDly[2:0], saveReq && !srst};
      detDly <= {detDly[2:0], detachReq && !srst};
   end

   // Host only pulls low; the pull-up alone lifts the line
   assign powerKeyIn = keyDrvLow ? 1'b0 : (keyPullUpEn ? 1'b1 : flip);
   assign resetLineIn = rstDrvLow ? 1'b0 : (resetPullUpEn ? 1'b1 : flip);
   // Firmware completion is a level, held only while the request stands
   assign saveDone = saveReq && (slow ? saveDly[3] : saveDly[0]);
   assign detachDone = detachReq && (slow ? detDly[3] : detDly[0]);
endmodule

// [sim/mps_sequencer_assertions.sv]
// Checker for the power sequencer, bound to its top module.
// Assumes the simulation filter minimum of 3 cycles on the reset line.
`timescale 1ns/100ps
`include "mps_params.svh"

module mps_seq_assertions #(
   parameter int unsigned KEY_MIN_CYC = 4, // Power key low
   parameter int unsigned RST_MIN_CYC = 3 // Reset line low
) (
   input wire logic sys_clk, // 125 MHz clock
   input wire logic srst, // Synchronous reset
   input wire logic supplyGood, // Main supply good
   input wire logic powerKeyIn, // Key line
   input wire logic resetLineIn, // Reset line
   input wire logic rtcAlarm, // Alarm
   input wire logic powerOffCmd, // Off command
   input wire logic funcResetCmd, // Reset command
   input wire logic tempSupEnable, // Supervisor on
   input wire logic tempSupConfigured, // Limits set
   input wire logic tempOverLimit, // Too hot
   input wire logic tempUnderLimit, // Too cold
   input wire logic saveDone, // Stored
   input wire logic detachDone, // Detached
   input wire logic saveReq, // Store request
   input wire logic detachReq, // Detach request
   input wire logic intSupplyEn, // Interface supply
   input wire logic pinsHiZ, // Pins released
   input wire logic coreRun, // Core running
   input wire logic rtcFromMain, // Clock block source
   input wire logic keyPullUpEn, // Key pull-up
   input wire logic resetPullUpEn, // Reset pull-up
   input wire logic [`MPS_STATE_W-1:0] powerState // State
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   property p_supply_off;
      !supplyGood |=> powerState == 8'h01;
   endproperty
   a_supply_off: assert property (p_supply_off) else $error("no drop on supply loss");
   property p_pins_off;
      pinsHiZ == !intSupplyEn && coreRun == intSupplyEn;
   endproperty
   a_pins_off: assert property (p_pins_off) else $error("pins not released");
   property p_if_supply;
      intSupplyEn == (powerState inside {8'h08, 8'h10, 8'h20});
   endproperty
   a_if_supply: assert property (p_if_supply) else $error("interface supply wrong");
   property p_pullups;
      keyPullUpEn && resetPullUpEn;
   endproperty
   a_pullups: assert property (p_pullups) else $error("pull-up off");
   property p_save_req;
      // An abrupt cut in the first save cycle is allowed to drop the request
      $rose(powerState == 8'h10) && supplyGood && $past(resetLineIn) |=> saveReq;
   endproperty
   a_save_req: assert property (p_save_req) else $error("no store request");
   property p_hwrst_quiet;
      powerState == 8'h40 && $past(powerState) == 8'h40 |-> !saveReq && !detachReq;
   endproperty
   a_hwrst_quiet: assert property (p_hwrst_quiet) else $error("request in reset");
   property p_reboot;
      powerState == 8'h80 && supplyGood |=> powerState == 8'h08;
   endproperty
   a_reboot: assert property (p_reboot) else $error("reboot not one cycle");
   property p_rst_wake;
      (!resetLineIn)[*5] ##1 (resetLineIn && powerState == 8'h04 && supplyGood)
         |-> ##[1:3] powerState == 8'h08;
   endproperty
   a_rst_wake: assert property (p_rst_wake) else $error("no wake on release");
   property p_temp;
      powerState == 8'h08 && supplyGood && resetLineIn && $past(resetLineIn) && tempSupEnable
         && tempSupConfigured && (tempOverLimit || tempUnderLimit) |=> powerState == 8'h04;
   endproperty
   a_temp: assert property (p_temp) else $error("no temperature trip");
endmodule

bind mps_sequencer mps_seq_assertions #(.KEY_MIN_CYC(KEY_MIN_CYC),
   .RST_MIN_CYC(RST_MIN_CYC)) u_chk (
   .sys_clk(sys_clk), .srst(srst), .supplyGood(supplyGood), .powerKeyIn(powerKeyIn),
   .resetLineIn(resetLineIn), .rtcAlarm(rtcAlarm), .powerOffCmd(powerOffCmd),
   .funcResetCmd(funcResetCmd), .tempSupEnable(tempSupEnable),
   .tempSupConfigured(tempSupConfigured), .tempOverLimit(tempOverLimit),
   .tempUnderLimit(tempUnderLimit), .saveDone(saveDone), .detachDone(detachDone),
   .saveReq(saveReq), .detachReq(detachReq), .intSupplyEn(intSupplyEn),
   .pinsHiZ(pinsHiZ), .coreRun(coreRun), .rtcFromMain(rtcFromMain),
   .keyPullUpEn(keyPullUpEn), .resetPullUpEn(resetPullUpEn), .powerState(powerState)
);

// [sim/mps_sequencer_tb.sv]
// Self-checking bench for the power sequencer with a host model.
// Assumes short filter minimums of 4 and 3 cycles; inputs change at falling edge.
`timescale 1ns/100ps

module mps_sequencer_tb;
   logic sys_clk, srst, supplyGood, rtcAlarm, powerOffCmd, funcResetCmd;
   logic tempSupEnable, tempSupConfigured, tempOverLimit, tempUnderLimit;
   logic keyDrvLow, rstDrvLow, slow, powerKeyIn, resetLineIn, saveDone, detachDone;
   logic saveReq, detachReq, intSupplyEn, pinsHiZ, coreRun, rtcFromMain;
   logic keyPullUpEn, resetPullUpEn;
   logic [7:0] powerState;
   int error_cnt = 0;
   int compares = 0;

   mps_sequencer #(.KEY_MIN_CYC(4), .RST_MIN_CYC(3)) i_dut (
      .sys_clk(sys_clk), .srst(srst), .supplyGood(supplyGood), .powerKeyIn(powerKeyIn),
      .resetLineIn(resetLineIn), .rtcAlarm(rtcAlarm), .powerOffCmd(powerOffCmd),
      .funcResetCmd(funcResetCmd), .tempSupEnable(tempSupEnable),
      .tempSupConfigured(tempSupConfigured), .tempOverLimit(tempOverLimit),
      .tempUnderLimit(tempUnderLimit), .saveDone(saveDone), .detachDone(detachDone),
      .saveReq(saveReq), .detachReq(detachReq), .intSupplyEn(intSupplyEn),
      .pinsHiZ(pinsHiZ), .coreRun(coreRun), .rtcFromMain(rtcFromMain),
      .keyPullUpEn(keyPullUpEn), .resetPullUpEn(resetPullUpEn), .powerState(powerState)
   );
   mps_host_model i_host (
      .sys_clk(sys_clk), .srst(srst), .keyDrvLow(keyDrvLow), .rstDrvLow(rstDrvLow),
      .slow(slow), .keyPullUpEn(keyPullUpEn), .resetPullUpEn(resetPullUpEn),
      .saveReq(saveReq), .detachReq(detachReq), .powerKeyIn(powerKeyIn),
      .resetLineIn(resetLineIn), .saveDone(saveDone), .detachDone(detachDone)
   );

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   task automatic report_and_stop();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Bounded wait for a state; running out ends the run
   task automatic wait_state(input logic [7:0] exp);
      for (int i = 0; i < 60 && powerState !== exp; i++) @(negedge sys_clk);
      chk("powerState", exp, powerState);
      if (powerState !== exp) report_and_stop();
   endtask

   // Open-drain low pulse of n cycles on the key or reset line
   task automatic pulse(input bit onRst, input int n);
      if (onRst) rstDrvLow = 1'b1;
      else keyDrvLow = 1'b1;
      repeat (n) @(negedge sys_clk);
      rstDrvLow = 1'b0;
      keyDrvLow = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask

   task automatic s_hold_on();
      keyDrvLow = 1'b1;
      supplyGood = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk("powerState", 8'h02, powerState);
      keyDrvLow = 1'b0;
      wait_state(8'h08);
      chk("intSupplyEn", 8'h01, {7'h0, intSupplyEn});
      chk("pullUps", 8'h03, {6'h0, keyPullUpEn, resetPullUpEn});
   endtask

   task automatic s_key_off();
      pulse(1'b0, 2);
      repeat (4) @(negedge sys_clk);
      chk("powerState", 8'h08, powerState);
      slow = 1'b1;
      pulse(1'b0, 5);
      wait_state(8'h10);
      wait_state(8'h20);
      @(negedge sys_clk);
      chk("detachReq", 8'h01, {7'h0, detachReq});
      wait_state(8'h04);
      chk("pinsHiZ", 8'h01, {7'h0, pinsHiZ});
      pulse(1'b0, 5);
      wait_state(8'h08);
   endtask

   task automatic s_cmd_off();
      slow = 1'b0;
      powerOffCmd = 1'b1;
      @(negedge sys_clk);
      powerOffCmd = 1'b0;
      wait_state(8'h10);
      wait_state(8'h04);
      pulse(1'b1, 5);
      wait_state(8'h08);
      funcResetCmd = 1'b1;
      @(negedge sys_clk);
      funcResetCmd = 1'b0;
      wait_state(8'h80);
      wait_state(8'h08);
   endtask

   task automatic s_hw_reset();
      rstDrvLow = 1'b1;
      wait_state(8'h40);
      chk("intSupplyEn", 8'h00, {7'h0, intSupplyEn});
      chk("saveReq", 8'h00, {7'h0, saveReq});
      rstDrvLow = 1'b0;
      wait_state(8'h08);
      // Reset line pulled while a graceful off is still saving
      slow = 1'b1;
      powerOffCmd = 1'b1;
      @(negedge sys_clk);
      powerOffCmd = 1'b0;
      wait_state(8'h10);
      rstDrvLow = 1'b1;
      wait_state(8'h40);
      chk("saveReq", 8'h00, {7'h0, saveReq});
      chk("detachReq", 8'h00, {7'h0, detachReq});
      chk("coreRun", 8'h00, {7'h0, coreRun});
      chk("pinsHiZ", 8'h01, {7'h0, pinsHiZ});
      rstDrvLow = 1'b0;
      wait_state(8'h08);
   endtask

   task automatic s_temp_alarm();
      tempSupEnable = 1'b1;
      tempOverLimit = 1'b1;
      repeat (5) @(negedge sys_clk);
      chk("powerState", 8'h08, powerState);
      tempSupConfigured = 1'b1;
      wait_state(8'h04);
      tempOverLimit = 1'b0;
      rtcAlarm = 1'b1;
      wait_state(8'h08);
      rtcAlarm = 1'b0;
      tempUnderLimit = 1'b1;
      wait_state(8'h04);
      tempUnderLimit = 1'b0;
      rtcAlarm = 1'b1;
      wait_state(8'h08);
      // Supply lost in the first save cycle: nothing may be stored
      powerOffCmd = 1'b1;
      @(negedge sys_clk);
      powerOffCmd = 1'b0;
      supplyGood = 1'b0;
      wait_state(8'h01);
      chk("saveReq", 8'h00, {7'h0, saveReq});
      @(negedge sys_clk);
      chk("rtcFromMain", 8'h00, {7'h0, rtcFromMain});
   endtask

   initial begin
      {srst, supplyGood, rtcAlarm, powerOffCmd, funcResetCmd} = 5'h10;
      {tempSupEnable, tempSupConfigured, tempOverLimit, tempUnderLimit} = 4'h0;
      {keyDrvLow, rstDrvLow, slow} = 3'h0;
      repeat (6) @(negedge sys_clk);
      srst = 1'b0;
      chk("powerState", 8'h01, powerState);
      s_hold_on();
      s_key_off();
      s_cmd_off();
      s_hw_reset();
      s_temp_alarm();
      report_and_stop();
   end
endmodule
